// *** src/ppc_defines.svh ***
// Purpose: constants for the port p pin control block
// Assumes: byte-wide registers, each on its own aligned apb word
// Notes:   printed offsets are register indexes; byte address is four times
`ifndef PPC_DEFINES_SVH
`define PPC_DEFINES_SVH
`define PPC_IDX_DATA      8'h18
`define PPC_IDX_PIN_INPUT 8'h19
`define PPC_IDX_DIRECTION 8'h1A
`define PPC_IDX_DRIVE     8'h1B
`define PPC_IDX_PULL_EN   8'h1C
`define PPC_IDX_POLARITY  8'h1D
`define PPC_IDX_IRQ_EN    8'h1E
`define PPC_IDX_IRQ_FLAG  8'h1F
`define PPC_IDX_ROUTING   8'h17
`define PPC_ROUTE_SPI_B   5
`define PPC_ROUTE_SPI_C   6
`define PPC_RST_BYTE      8'h00
`define PPC_ADDR_W        12
`endif

// *** src/ppc_pkg.sv ***
// Purpose: shared types for the port p pin control block
// Assumes: eight pins per port
// Notes:   constants live in ppc_defines.svh
package ppc_pkg;
  typedef logic [7:0]  ppc_byte_t;
  typedef logic [31:0] ppc_word_t;
  typedef enum logic [1:0] {
    PPC_OWN_GPIO = 2'b00,
    PPC_OWN_SPI  = 2'b01,
    PPC_OWN_PWM  = 2'b11
  } ppc_owner_e;
endpackage : ppc_pkg

// *** src/ppc_port_p.sv ***
// Purpose: port p pin control with pwm/spi sharing, spi routing and edge interrupts
// Assumes: apb slave on mclk, zero wait states, pins synchronised internally
// Notes:   pad strength and pull signals are per-pin outputs toward the pad ring
`timescale 1ns/100ps
`default_nettype none
`include "ppc_defines.svh"

module ppc_port_p #(
  parameter int NUM_MODULES = 3
) (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`PPC_ADDR_W-1:0]   paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // pwm channels
  input  wire logic [7:0]               pwm_enable,
  input  wire logic [7:0]               pwm_out,
  input  wire logic                     pwm_shutdown_en,
  // spi_b and spi_c pin requests: bits 3:0 miso, mosi, sck, ss
  input  wire logic                     spi_b_enable,
  input  wire logic [3:0]               spi_b_out,
  input  wire logic [3:0]               spi_b_oe,
  input  wire logic                     spi_c_enable,
  input  wire logic [3:0]               spi_c_out,
  input  wire logic [3:0]               spi_c_oe,
  output logic      [3:0]               spi_b_in,
  output logic      [3:0]               spi_c_in,
  output logic                          pwm7_in,
  // port p pins
  input  wire logic [7:0]               port_p_pin_level,
  output logic      [7:0]               port_p_pin_drive,
  output logic      [7:0]               port_p_pin_oe,
  output logic      [7:0]               port_p_reduced,
  output logic      [7:0]               port_p_pull_up,
  output logic      [7:0]               port_p_pull_down,
  // routing toward port h
  output logic                          spi_b_to_port_h,
  output logic                          spi_c_to_port_h,
  // interrupt
  output logic                          port_p_irq
);
  import ppc_pkg::*;

  localparam bit HAS_SPI_B = (NUM_MODULES >= 2);
  localparam bit HAS_SPI_C = (NUM_MODULES >= 3);

  ppc_byte_t data_reg, dir_reg, drive_reg, pull_reg, pol_reg, ie_reg, flag_reg;
  ppc_byte_t route_reg;
  ppc_byte_t sync1_reg, sync2_reg, prev_reg;
  ppc_byte_t pin_o_next, pin_oe_next, rd_byte;
  ppc_byte_t edge_hit;
  logic      spi_b_act, spi_c_act;
  logic      wr_stb, rd_stb, addr_ok;
  logic [7:0] idx;
  ppc_owner_e owner [8];

  // spi_a routing to port m lives in the port m block; nothing here
  assign idx    = paddr[9:2];
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[`PPC_ADDR_W-1:10] == '0) &&
                   (idx >= `PPC_IDX_ROUTING) && (idx <= `PPC_IDX_IRQ_FLAG);
  assign wr_stb = psel && penable && pwrite && addr_ok && pstrb[0];
  assign rd_stb = psel && !penable && !pwrite;

  // spi units active on port p only when not rerouted to port h
  assign spi_b_act = HAS_SPI_B && spi_b_enable && !route_reg[`PPC_ROUTE_SPI_B];
  assign spi_c_act = HAS_SPI_C && spi_c_enable && !route_reg[`PPC_ROUTE_SPI_C];

  // two stage synchroniser
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1_reg <= `PPC_RST_BYTE;
      sync2_reg <= `PPC_RST_BYTE;
      prev_reg  <= `PPC_RST_BYTE;
    end else begin
      sync1_reg <= port_p_pin_level;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // per-pin ownership and drive
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      logic spi_act;
      logic spi_o;
      logic spi_oe;
      assign spi_act = (g < 4) ? spi_b_act : spi_c_act;
      assign spi_o   = (g < 4) ? spi_b_out[g % 4] : spi_c_out[g % 4];
      assign spi_oe  = (g < 4) ? spi_b_oe[g % 4] : spi_c_oe[g % 4];
      always_comb begin
        if (pwm_enable[g]) begin
          owner[g] = PPC_OWN_PWM;
        end else if (spi_act) begin
          owner[g] = PPC_OWN_SPI;
        end else begin
          owner[g] = PPC_OWN_GPIO;
        end
      end
      always_comb begin
        case (owner[g])
          PPC_OWN_PWM: begin
            pin_o_next[g]  = pwm_out[g];
            pin_oe_next[g] = (g == 7) ? !pwm_shutdown_en : 1'b1;
          end
          PPC_OWN_SPI: begin
            pin_o_next[g]  = spi_o;
            pin_oe_next[g] = spi_oe;
          end
          default: begin
            pin_o_next[g]  = data_reg[g];
            pin_oe_next[g] = dir_reg[g];
          end
        endcase
      end
      assign edge_hit[g] = pol_reg[g] ? (sync2_reg[g] && !prev_reg[g])
                                      : (!sync2_reg[g] && prev_reg[g]);
    end
  endgenerate

  // pad control outputs, all registered
  always_ff @(posedge mclk) begin
    if (rst) begin
      port_p_pin_drive <= `PPC_RST_BYTE;
      port_p_pin_oe    <= `PPC_RST_BYTE;
      port_p_reduced   <= `PPC_RST_BYTE;
      port_p_pull_up   <= `PPC_RST_BYTE;
      port_p_pull_down <= `PPC_RST_BYTE;
    end else begin
      port_p_pin_drive <= pin_o_next;
      port_p_pin_oe    <= pin_oe_next;
      port_p_reduced   <= drive_reg & pin_oe_next;
      port_p_pull_up   <= pull_reg & ~pin_oe_next & ~pol_reg;
      port_p_pull_down <= pull_reg & ~pin_oe_next & pol_reg;
    end
  end

  // peripheral input side
  always_ff @(posedge mclk) begin
    if (rst) begin
      spi_b_in        <= 4'h0;
      spi_c_in        <= 4'h0;
      pwm7_in         <= 1'b0;
      spi_b_to_port_h <= 1'b0;
      spi_c_to_port_h <= 1'b0;
    end else begin
      spi_b_in        <= sync2_reg[3:0];
      spi_c_in        <= sync2_reg[7:4];
      pwm7_in         <= sync2_reg[7];
      spi_b_to_port_h <= HAS_SPI_B && route_reg[`PPC_ROUTE_SPI_B];
      spi_c_to_port_h <= HAS_SPI_C && route_reg[`PPC_ROUTE_SPI_C];
    end
  end

  // software registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      data_reg  <= `PPC_RST_BYTE;
      dir_reg   <= `PPC_RST_BYTE;
      drive_reg <= `PPC_RST_BYTE;
      pull_reg  <= `PPC_RST_BYTE;
      pol_reg   <= `PPC_RST_BYTE;
      ie_reg    <= `PPC_RST_BYTE;
      route_reg <= `PPC_RST_BYTE;
    end else if (wr_stb) begin
      case (idx)
        `PPC_IDX_DATA:      data_reg  <= pwdata[7:0];
        `PPC_IDX_DIRECTION: dir_reg   <= pwdata[7:0];
        `PPC_IDX_DRIVE:     drive_reg <= pwdata[7:0];
        `PPC_IDX_PULL_EN:   pull_reg  <= pwdata[7:0];
        `PPC_IDX_POLARITY:  pol_reg   <= pwdata[7:0];
        `PPC_IDX_IRQ_EN:    ie_reg    <= pwdata[7:0];
        `PPC_IDX_ROUTING:   route_reg <= {1'b0, pwdata[6:5], 5'h00};
        default:            route_reg <= route_reg;
      endcase
    end
  end

  // edge flags: set wins over a write-one clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      flag_reg <= `PPC_RST_BYTE;
    end else begin
      flag_reg <= (flag_reg & ~((wr_stb && idx == `PPC_IDX_IRQ_FLAG) ? pwdata[7:0] : 8'h00))
                  | edge_hit;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      port_p_irq <= 1'b0;
    end else begin
      port_p_irq <= |(flag_reg & ie_reg);
    end
  end

  // read mux
  always_comb begin
    case (idx)
      `PPC_IDX_DATA:      rd_byte = (data_reg & dir_reg) | (sync2_reg & ~dir_reg);
      `PPC_IDX_PIN_INPUT: rd_byte = sync2_reg;
      `PPC_IDX_DIRECTION: rd_byte = dir_reg;
      `PPC_IDX_DRIVE:     rd_byte = drive_reg;
      `PPC_IDX_PULL_EN:   rd_byte = pull_reg;
      `PPC_IDX_POLARITY:  rd_byte = pol_reg;
      `PPC_IDX_IRQ_EN:    rd_byte = ie_reg;
      `PPC_IDX_IRQ_FLAG:  rd_byte = flag_reg;
      `PPC_IDX_ROUTING:   rd_byte = route_reg;
      default:            rd_byte = 8'h00;
    endcase
  end

  // apb answer: ready one cycle after setup
  always_ff @(posedge mclk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd_stb) begin
        prdata <= {24'h00_0000, addr_ok ? rd_byte : 8'h00};
      end
    end
  end

  property p_reset_hiz;
    @(posedge mclk) $past(rst) |-> port_p_pin_oe == 8'h00;
  endproperty
  a_reset_hiz: assert property (p_reset_hiz) else $error("pins driven after reset");

  property p_pwm_wins;
    @(posedge mclk) disable iff (rst)
      (pwm_enable[0] && spi_b_act) |=> port_p_pin_drive[0] == $past(pwm_out[0]);
  endproperty
  a_pwm_wins: assert property (p_pwm_wins) else $error("pwm lost pin priority");

  property p_pwm_out;
    @(posedge mclk) disable iff (rst) pwm_enable[0] |=> port_p_pin_oe[0];
  endproperty
  a_pwm_out: assert property (p_pwm_out) else $error("pwm pin not output");

  property p_gpio_dir;
    @(posedge mclk) disable iff (rst)
      (!pwm_enable[1] && !spi_b_act) |=> port_p_pin_oe[1] == $past(dir_reg[1]);
  endproperty
  a_gpio_dir: assert property (p_gpio_dir) else $error("gpio direction wrong");

  property p_pull_input;
    @(posedge mclk) disable iff (rst) |(port_p_pull_up & port_p_pin_oe) == 1'b0;
  endproperty
  a_pull_input: assert property (p_pull_input) else $error("pull on output pin");

  sequence s_rise2;
    !sync2_reg[2] ##1 sync2_reg[2] && pol_reg[2];
  endsequence
  property p_flag_set;
    @(posedge mclk) disable iff (rst) s_rise2 |=> flag_reg[2];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("rising edge missed");

  property p_irq;
    @(posedge mclk) disable iff (rst) |(flag_reg & ie_reg) |=> port_p_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");

  property p_irq_mask;
    @(posedge mclk) disable iff (rst) (flag_reg & ie_reg) == 8'h00 |=> !port_p_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq raised");

  property p_input_ro;
    @(posedge mclk) disable iff (rst)
      (wr_stb && idx == `PPC_IDX_PIN_INPUT) |=> $stable(dir_reg) && $stable(data_reg);
  endproperty
  a_input_ro: assert property (p_input_ro) else $error("input write had effect");

  // pwm channel 7 turns input under shutdown
  property p_pwm7_input;
    @(posedge mclk) disable iff (rst)
      (pwm_enable[7] && pwm_shutdown_en) |=> !port_p_pin_oe[7];
  endproperty
  a_pwm7_input: assert property (p_pwm7_input) else $error("pwm7 still driving");

  // enabled spi_c sets direction of its pins
  property p_spi_dir;
    @(posedge mclk) disable iff (rst)
      (!pwm_enable[5] && spi_c_act) |=> port_p_pin_oe[5] == $past(spi_c_oe[1]);
  endproperty
  a_spi_dir: assert property (p_spi_dir) else $error("spi direction ignored");

  // rerouted spi_b hands its pins back to gpio
  property p_route_away;
    @(posedge mclk) disable iff (rst)
      (route_reg[`PPC_ROUTE_SPI_B] && !pwm_enable[2])
        |=> port_p_pin_oe[2] == $past(dir_reg[2]);
  endproperty
  a_route_away: assert property (p_route_away) else $error("rerouted pin kept");

  // reduced drive never reaches an input pin
  property p_reduced_out;
    @(posedge mclk) disable iff (rst) (port_p_reduced & ~port_p_pin_oe) == 8'h00;
  endproperty
  a_reduced_out: assert property (p_reduced_out) else $error("reduced on input");

  // no pull device right after reset
  property p_pull_reset;
    @(posedge mclk) $past(rst) |-> (port_p_pull_up | port_p_pull_down) == 8'h00;
  endproperty
  a_pull_reset: assert property (p_pull_reset) else $error("pull on after reset");

  // falling edge with polarity 0 sets the flag
  sequence s_fall3;
    sync2_reg[3] ##1 !sync2_reg[3] && !pol_reg[3];
  endsequence
  property p_flag_fall;
    @(posedge mclk) disable iff (rst) s_fall3 |=> flag_reg[3];
  endproperty
  a_flag_fall: assert property (p_flag_fall) else $error("falling edge missed");

  // write-one clear without a new edge empties the flag
  sequence s_clear1;
    wr_stb && idx == `PPC_IDX_IRQ_FLAG && pwdata[1] && !edge_hit[1];
  endsequence
  property p_flag_clear;
    @(posedge mclk) disable iff (rst) s_clear1 |=> !flag_reg[1];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  // an edge wins over a same-cycle clear
  property p_set_wins;
    @(posedge mclk) disable iff (rst) edge_hit[1] |=> flag_reg[1];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("edge lost");

  // unmapped index answers with an error
  property p_bad_addr;
    @(posedge mclk) disable iff (rst) (psel && !penable && !addr_ok) |=> pready && pslverr;
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("no error on bad index");

  // input register reads the synchronised pins
  property p_read_input;
    @(posedge mclk) disable iff (rst)
      (rd_stb && idx == `PPC_IDX_PIN_INPUT) |=> prdata[7:0] == $past(sync2_reg);
  endproperty
  a_read_input: assert property (p_read_input) else $error("input read wrong");

  // pins reach logic after exactly two stages
  property p_sync_depth;
    @(posedge mclk) disable iff (rst)
      (!$past(rst) && !$past(rst, 2)) |-> sync2_reg == $past(port_p_pin_level, 2);
  endproperty
  a_sync_depth: assert property (p_sync_depth) else $error("sync depth wrong");

endmodule : ppc_port_p
`default_nettype wire

// *** dv/ppc_pin_model.sv ***
// Purpose: pad model resolving port p pin levels
// Assumes: driven pins win, then outside driver, then pulls
// Notes:   floating pins toggle so no stale level survives
`timescale 1ns/100ps
`default_nettype none
module ppc_pin_model (
  // clock
  input  wire logic       mclk,
  // pad side of block
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pull_up,
  input  wire logic [7:0] pull_down,
  // outside world
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext,
  output logic      [7:0] pin
);
  logic [7:0] held = 8'h00;
  always @(posedge mclk) begin
    held <= ~held;
  end
  assign pin = (pin_oe & pin_o) | (~pin_oe & ext_en & ext)
             | (~pin_oe & ~ext_en & (pull_up | (~pull_down & held)));
endmodule : ppc_pin_model
`default_nettype wire

// *** dv/tb_port_p_pin_control.sv ***
// Purpose: self-checking bench for the port p pin control block
// Assumes: zero-wait apb, registered pad outputs
// Notes:   byte address is four times the register index
`timescale 1ns/100ps
`default_nettype none
`include "ppc_defines.svh"
`define CK(n, e, s) begin tests_run++; if ((s) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb_port_p_pin_control;
  import ppc_pkg::*;
  logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, pwm_sd = 0, sb_en = 0, sc_en = 0, pwm7_in;
  logic [7:0] pwm_en = 8'h00, pwm_o = 8'h00, ext_en = 8'hFF, ext = 8'h00;
  logic [3:0] sb_o = 4'h0, sb_oe = 4'h0, sc_o = 4'h0, sc_oe = 4'h0, sb_i, sc_i;
  logic [7:0] pin, p_o, p_oe, p_rd, p_pu, p_pd;
  logic sb_h, sc_h, irq, sc_h2;
  int mismatches = 0, tests_run = 0, cyc = 0;
  always #2.5 mclk = ~mclk;
  ppc_port_p u_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwm_enable(pwm_en), .pwm_out(pwm_o),
    .pwm_shutdown_en(pwm_sd), .spi_b_enable(sb_en), .spi_b_out(sb_o), .spi_b_oe(sb_oe),
    .spi_c_enable(sc_en), .spi_c_out(sc_o), .spi_c_oe(sc_oe), .spi_b_in(sb_i),
    .spi_c_in(sc_i), .pwm7_in(pwm7_in), .port_p_pin_level(pin), .port_p_pin_drive(p_o),
    .port_p_pin_oe(p_oe), .port_p_reduced(p_rd), .port_p_pull_up(p_pu),
    .port_p_pull_down(p_pd), .spi_b_to_port_h(sb_h), .spi_c_to_port_h(sc_h),
    .port_p_irq(irq));
  // two-unit variant: spi_c must stay absent
  ppc_port_p #(.NUM_MODULES(2)) u_dut_two (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(), .pready(), .pslverr(), .pwm_enable(pwm_en), .pwm_out(pwm_o),
    .pwm_shutdown_en(pwm_sd), .spi_b_enable(sb_en), .spi_b_out(sb_o), .spi_b_oe(sb_oe),
    .spi_c_enable(sc_en), .spi_c_out(sc_o), .spi_c_oe(sc_oe), .spi_b_in(), .spi_c_in(),
    .pwm7_in(), .port_p_pin_level(pin), .port_p_pin_drive(), .port_p_pin_oe(),
    .port_p_reduced(), .port_p_pull_up(), .port_p_pull_down(), .spi_b_to_port_h(),
    .spi_c_to_port_h(sc_h2), .port_p_irq());
  ppc_pin_model u_pins (.mclk(mclk), .pin_o(p_o), .pin_oe(p_oe), .pull_up(p_pu),
    .pull_down(p_pd), .ext_en(ext_en), .ext(ext), .pin(pin));
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge mclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : xfer
  task automatic settle();
    repeat (6) @(posedge mclk);
  endtask : settle
  task automatic t_reset();
    `CK("oe", 8'h00, p_oe)
    for (int i = 8'h17; i <= 8'h1F; i++) begin
      xfer(0, i[7:0], 8'h00);
      `CK("reset value", 32'h0, rd)
    end
  endtask : t_reset
  task automatic t_gpio();
    xfer(1, `PPC_IDX_DIRECTION, 8'hF0);
    xfer(1, `PPC_IDX_DATA, 8'hA5);
    ext <= 8'h3C;
    settle();
    `CK("oe", 8'hF0, p_oe)
    `CK("out", 4'hA, p_o[7:4])
    xfer(0, `PPC_IDX_DATA, 8'h00);
    `CK("data", 32'hAC, rd)
    xfer(1, `PPC_IDX_PIN_INPUT, 8'h5A);
    xfer(0, `PPC_IDX_PIN_INPUT, 8'h00);
    `CK("input", 32'hAC, rd)
    `CK("spi_b in", 4'hC, sb_i)
    `CK("spi_c in", 4'hA, sc_i)
    `CK("pwm7 in", 1'b1, pwm7_in)
  endtask : t_gpio
  task automatic t_pads();
    xfer(1, `PPC_IDX_DRIVE, 8'hFF);
    xfer(1, `PPC_IDX_PULL_EN, 8'hFF);
    xfer(1, `PPC_IDX_POLARITY, 8'h05);
    ext_en <= 8'hF0;
    settle();
    `CK("reduced", 8'hF0, p_rd)
    `CK("pull up", 8'h0A, p_pu)
    `CK("pull down", 8'h05, p_pd)
    xfer(0, `PPC_IDX_PIN_INPUT, 8'h00);
    `CK("pulled input", 32'hAA, rd)
    ext_en <= 8'hFF;
  endtask : t_pads
  task automatic t_share();
    pwm_en <= 8'h81; pwm_o <= 8'hFF; sb_en <= 1; sb_oe <= 4'hF; sb_o <= 4'h0;
    settle();
    `CK("oe", 8'hFF, p_oe)
    `CK("out", 8'hA1, p_o)
    pwm_sd <= 1;
    settle();
    `CK("oe", 8'h7F, p_oe)
    xfer(1, `PPC_IDX_ROUTING, 8'h20);
    settle();
    `CK("route b", 1'b1, sb_h)
    `CK("route c", 1'b0, sc_h)
    `CK("oe", 8'h71, p_oe)
    xfer(0, `PPC_IDX_ROUTING, 8'h00);
    `CK("routing", 32'h20, rd)
    xfer(1, `PPC_IDX_ROUTING, 8'h60);
    settle();
    `CK("route c", 1'b1, sc_h)
    `CK("two-unit route c", 1'b0, sc_h2)
    xfer(1, `PPC_IDX_ROUTING, 8'h00);
    pwm_en <= 8'h00; pwm_sd <= 0; sc_en <= 1; sc_oe <= 4'hF; sc_o <= 4'hF;
    settle();
    `CK("oe", 8'hFF, p_oe)
    `CK("out", 8'hF0, p_o)
    sb_en <= 0; sc_en <= 0;
    settle();
    `CK("oe", 8'hF0, p_oe)
  endtask : t_share
  task automatic t_irq();
    ext <= 8'hFF;
    xfer(1, `PPC_IDX_IRQ_EN, 8'h02);
    settle();
    xfer(1, `PPC_IDX_IRQ_FLAG, 8'hFF);
    ext <= 8'hFD;
    settle();
    `CK("irq", 1'b1, irq)
    xfer(1, `PPC_IDX_IRQ_FLAG, 8'h00);
    xfer(0, `PPC_IDX_IRQ_FLAG, 8'h00);
    `CK("flag", 32'h02, rd)
    xfer(1, `PPC_IDX_IRQ_FLAG, 8'h02);
    settle();
    `CK("irq", 1'b0, irq)
    xfer(1, `PPC_IDX_IRQ_EN, 8'h00);
    ext <= 8'hF5;
    settle();
    xfer(0, `PPC_IDX_IRQ_FLAG, 8'h00);
    `CK("flag", 32'h08, rd)
    `CK("masked irq", 1'b0, irq)
    xfer(0, 8'h00, 8'h00);
    `CK("unmapped", 1'b1, err)
    `CK("unmapped data", 32'h0, rd)
  endtask : t_irq
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    t_reset();
    t_gpio();
    t_pads();
    t_share();
    t_irq();
    test_done();
  end
endmodule : tb_port_p_pin_control
`default_nettype wire
